// >>> ums_consts.vh
// Register map, field positions and reset values of the UART status block
`ifndef UMS_CONSTS_VH
`define UMS_CONSTS_VH

// ****************************************************************
// Register byte offsets on the APB word grid
// ****************************************************************
`define UMS_ADDR_W          8
`define UMS_OFF_RX_DATA     8'h00
`define UMS_OFF_LINE_STATUS 8'h04
`define UMS_OFF_MODEM_STAT  8'h08
`define UMS_OFF_MODEM_CTRL  8'h0C
`define UMS_OFF_LINE_CFG    8'h10
`define UMS_OFF_IRQ_STATUS  8'h14
`define UMS_OFF_IRQ_MASK    8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define UMS_LS_DATA_READY   0
`define UMS_LS_OVERRUN      1
`define UMS_LS_PARITY       2
`define UMS_MC_DTR          0
`define UMS_MC_RTS          1
`define UMS_MC_OUT1         2
`define UMS_MC_OUT2         3
`define UMS_MC_LOOP         4
`define UMS_LC_PAR_EN       0
`define UMS_LC_PAR_EVEN     1
`define UMS_LC_FIFO_EN      2
`define UMS_LC_WLEN_LO      3
`define UMS_LC_WLEN_HI      4
`define UMS_EV_RX           0
`define UMS_EV_OVERRUN      1
`define UMS_EV_PARITY       2
`define UMS_EV_MODEM        3

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define UMS_EV_W            4
`define UMS_MC_W            5
`define UMS_LC_W            5
`define UMS_MC_RST          5'h00
`define UMS_LC_RST          5'h00
`define UMS_MASK_RST        4'h0
`define UMS_Q_DEPTH         16
`define UMS_Q_PTR_W         4
`define UMS_Q_CNT_W         5
`define UMS_Q_ENTRY_W       9
`define UMS_RISE_ONLY       4'h4

`endif

// >>> ums_rx_queue.v
// Receive holding queue: characters with their parity flag
`timescale 1ns/1ns
`include "ums_consts.vh"

module ums_rx_queue (
    // Clock and reset
    input  wire                          clk,
    input  wire                          reset_n,
    // Fill side
    input  wire                          push,
    input  wire [`UMS_Q_ENTRY_W-1:0]     push_data,
    input  wire                          cap_one,
    // Drain side
    input  wire                          pop,
    output wire [`UMS_Q_ENTRY_W-1:0]     head_data,
    output wire                          not_empty,
    output wire                          full
);

    reg [`UMS_Q_ENTRY_W-1:0] mem_q [0:`UMS_Q_DEPTH-1];
    reg [`UMS_Q_PTR_W-1:0]   wr_ptr_q;
    reg [`UMS_Q_PTR_W-1:0]   rd_ptr_q;
    reg [`UMS_Q_CNT_W-1:0]   count_q;
    wire                     do_push;
    wire                     do_pop;

    // Capacity is one entry when the queue is switched off
    assign full      = cap_one ? (count_q != 5'h00)
                               : (count_q == 5'h10);
    assign not_empty = (count_q != 5'h00);
    assign head_data = mem_q[rd_ptr_q];
    assign do_push   = push & ~full;
    assign do_pop    = pop & not_empty;

    // Storage, written at the write index
    always @(posedge clk) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= push_data;
        end
    end

    // Pointers and fill count
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= 4'h0;
            rd_ptr_q <= 4'h0;
            count_q  <= 5'h00;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 4'h1;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + 4'h1;
            end
            if (do_push && !do_pop) begin
                count_q <= count_q + 5'h01;
            end else if (do_pop && !do_push) begin
                count_q <= count_q - 5'h01;
            end
        end
    end

endmodule // ums_rx_queue

// >>> ums_modem_detect.v
// Change detector for the four modem input lines
`timescale 1ns/1ns
`include "ums_consts.vh"

module ums_modem_detect (
    // Clock and reset
    input  wire       clk,
    input  wire       reset_n,
    // Line levels: bit 0 cts, 1 dsr, 2 ri, 3 cd
    input  wire [3:0] line_level,
    input  wire       clear,
    // Sticky change bits and a one-cycle new-change pulse
    output wire [3:0] delta,
    output wire       change_pulse
);

    reg  [3:0] prev_q;
    reg        primed_q;
    reg  [3:0] delta_q;
    wire [3:0] edge_seen;
    wire [3:0] rise_only;

    assign rise_only = `UMS_RISE_ONLY;

    // Per line edge detect; ring line counts low to high only
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_line
            assign edge_seen[i] = primed_q &
                (rise_only[i] ? (line_level[i] & ~prev_q[i])
                              : (line_level[i] ^ prev_q[i]));
        end
    endgenerate

    // First cycle after reset only records levels, no false change
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q   <= 4'h0;
            primed_q <= 1'b0;
            delta_q  <= 4'h0;
        end else begin
            prev_q   <= line_level;
            primed_q <= 1'b1;
            delta_q  <= (delta_q & ~{4{clear}}) | edge_seen;
        end
    end

    assign delta        = delta_q;
    assign change_pulse = |edge_seen;

endmodule // ums_modem_detect

// >>> ums_status_top.v
// UART line and modem status block with APB register access
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "ums_consts.vh"

module ums_status_top (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Characters from the receive shifter
    input  wire        rx_char_valid,
    input  wire [7:0]  rx_char_data,
    input  wire        rx_char_parity,
    // Modem input lines, active low
    input  wire        cts_n,
    input  wire        dsr_n,
    input  wire        ri_n,
    input  wire        cd_n,
    // Modem output lines, active low
    output wire        dtr_n,
    output wire        rts_n,
    output wire        user_output_one_n,
    output wire        user_output_two_n,
    // Interrupts
    output wire        modem_irq,
    output wire        irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [`UMS_MC_W-1:0]     modem_output_control_q;
    reg  [`UMS_LC_W-1:0]     line_config_q;
    reg  [`UMS_EV_W-1:0]     irq_status_q;
    reg  [`UMS_EV_W-1:0]     irq_status_d;
    reg  [`UMS_EV_W-1:0]     irq_mask_q;
    reg                      overrun_q;
    reg  [31:0]              rdata_q;
    reg  [31:0]              rdata_d;
    reg                      hit_d;
    wire                     setup_rd;
    wire                     acc_rd;
    wire                     acc_wr;
    wire                     acc_any;
    wire                     loopback;
    wire [3:0]               line_level;
    wire [3:0]               modem_delta;
    wire                     modem_change;
    wire [7:0]               modem_input_status;
    wire [7:0]               line_status;
    wire [7:0]               data_mask;
    wire [7:0]               data_used;
    wire                     parity_sum;
    wire                     parity_bad;
    wire                     q_full;
    wire                     q_not_empty;
    wire [`UMS_Q_ENTRY_W-1:0] q_head;
    wire                     q_push;
    wire                     q_pop;
    wire                     overrun_event;
    wire [`UMS_EV_W-1:0]     events;
    wire [1:0]               word_len;

    // ****************************************************************
    // APB access decode
    // ****************************************************************

    // Setup phase latches read data, access phase commits effects
    assign setup_rd = psel & ~penable & ~pwrite;
    assign acc_any  = psel & penable;
    assign acc_rd   = acc_any & ~pwrite;
    assign acc_wr   = acc_any & pwrite;
    assign pready   = 1'b1;

    // Address hit check for the error answer
    always @* begin
        case (paddr)
            `UMS_OFF_RX_DATA:     hit_d = 1'b1;
            `UMS_OFF_LINE_STATUS: hit_d = 1'b1;
            `UMS_OFF_MODEM_STAT:  hit_d = 1'b1;
            `UMS_OFF_MODEM_CTRL:  hit_d = 1'b1;
            `UMS_OFF_LINE_CFG:    hit_d = 1'b1;
            `UMS_OFF_IRQ_STATUS:  hit_d = 1'b1;
            `UMS_OFF_IRQ_MASK:    hit_d = 1'b1;
            default:              hit_d = 1'b0;
        endcase
    end

    // Unmapped address answers with an error, no effect
    assign pslverr = acc_any & ~hit_d;

    // ****************************************************************
    // Modem control and loopback
    // ****************************************************************

    assign loopback = modem_output_control_q[`UMS_MC_LOOP];

    // Pins held inactive in loopback, control bits fed back inside
    assign dtr_n = loopback | ~modem_output_control_q[`UMS_MC_DTR];
    assign rts_n = loopback | ~modem_output_control_q[`UMS_MC_RTS];
    assign user_output_one_n =
        loopback | ~modem_output_control_q[`UMS_MC_OUT1];
    assign user_output_two_n =
        loopback | ~modem_output_control_q[`UMS_MC_OUT2];

    // Effective line levels, low meaning asserted
    assign line_level[0] = loopback
        ? ~modem_output_control_q[`UMS_MC_RTS]  : cts_n;
    assign line_level[1] = loopback
        ? ~modem_output_control_q[`UMS_MC_DTR]  : dsr_n;
    assign line_level[2] = loopback
        ? ~modem_output_control_q[`UMS_MC_OUT1] : ri_n;
    assign line_level[3] = loopback
        ? ~modem_output_control_q[`UMS_MC_OUT2] : cd_n;

    // ****************************************************************
    // Modem status register
    // ****************************************************************

    // Change bits cleared by a completed modem status read
    ums_modem_detect u_detect (
        .clk          (clk),
        .reset_n      (reset_n),
        .line_level   (line_level),
        .clear        (acc_rd & (paddr == `UMS_OFF_MODEM_STAT)),
        .delta        (modem_delta),
        .change_pulse (modem_change)
    );

    // Upper half is live, so it shows input levels from reset on
    assign modem_input_status = {~line_level, modem_delta};

    // Modem interrupt request while any change bit stands
    assign modem_irq = |modem_delta;

    // ****************************************************************
    // Receive path: parity check and holding queue
    // ****************************************************************

    assign word_len = line_config_q[`UMS_LC_WLEN_HI:`UMS_LC_WLEN_LO];

    // Only the configured 5..8 data bits take part in parity
    assign data_mask = (word_len == 2'h0) ? 8'h1F :
                       (word_len == 2'h1) ? 8'h3F :
                       (word_len == 2'h2) ? 8'h7F : 8'hFF;
    assign data_used = rx_char_data & data_mask;

    // Odd count of ones is an error for even format, and vice versa
    assign parity_sum = ^{data_used, rx_char_parity};
    assign parity_bad = line_config_q[`UMS_LC_PAR_EN] &
        (parity_sum ^ ~line_config_q[`UMS_LC_PAR_EVEN]);

    // Full queue drops the arriving character untouched
    assign q_push        = rx_char_valid & ~q_full;
    assign overrun_event = rx_char_valid & q_full;

    // Read of the data register takes the head character out
    assign q_pop = acc_rd & (paddr == `UMS_OFF_RX_DATA);

    // Flag travels with its character so the head shows its own
    ums_rx_queue u_queue (
        .clk       (clk),
        .reset_n   (reset_n),
        .push      (q_push),
        .push_data ({parity_bad, data_used}),
        .cap_one   (~line_config_q[`UMS_LC_FIFO_EN]),
        .pop       (q_pop),
        .head_data (q_head),
        .not_empty (q_not_empty),
        .full      (q_full)
    );

    // ****************************************************************
    // Line status register
    // ****************************************************************

    // Ready follows the queue fill, parity follows the head entry
    assign line_status = {5'h00,
                          q_not_empty & q_head[8],
                          overrun_q,
                          q_not_empty};

    // Overrun flag, cleared by a line status read, set wins
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overrun_q <= 1'b0;
        end else if (overrun_event) begin
            overrun_q <= 1'b1;
        end else if (acc_rd && paddr == `UMS_OFF_LINE_STATUS) begin
            overrun_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************

    assign events[`UMS_EV_RX]      = q_push;
    assign events[`UMS_EV_OVERRUN] = overrun_event;
    assign events[`UMS_EV_PARITY]  = rx_char_valid & parity_bad;
    assign events[`UMS_EV_MODEM]   = modem_change;

    // Write one to clear; a new event in the same cycle survives
    always @* begin
        irq_status_d = irq_status_q;
        if (acc_wr && paddr == `UMS_OFF_IRQ_STATUS) begin
            irq_status_d = irq_status_q & ~pwdata[`UMS_EV_W-1:0];
        end
        irq_status_d = irq_status_d | events;
    end

    // Level output while any unmasked sticky bit is set
    assign irq = |(irq_status_q & irq_mask_q);

    // ****************************************************************
    // Writable registers
    // ****************************************************************

    // Software writes take effect at the access edge
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            modem_output_control_q <= `UMS_MC_RST;
            line_config_q          <= `UMS_LC_RST;
            irq_mask_q             <= `UMS_MASK_RST;
            irq_status_q           <= 4'h0;
        end else begin
            irq_status_q <= irq_status_d;
            if (acc_wr) begin
                case (paddr)
                    `UMS_OFF_MODEM_CTRL: begin
                        modem_output_control_q <= pwdata[`UMS_MC_W-1:0];
                    end
                    `UMS_OFF_LINE_CFG: begin
                        line_config_q <= pwdata[`UMS_LC_W-1:0];
                    end
                    `UMS_OFF_IRQ_MASK: begin
                        irq_mask_q <= pwdata[`UMS_EV_W-1:0];
                    end
                    default: begin
                        irq_mask_q <= irq_mask_q;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Read data path
    // ****************************************************************

    // Read value selected from the address of the setup phase
    always @* begin
        case (paddr)
            `UMS_OFF_RX_DATA:
                rdata_d = {24'h000000, q_head[7:0]};
            `UMS_OFF_LINE_STATUS:
                rdata_d = {24'h000000, line_status};
            `UMS_OFF_MODEM_STAT:
                rdata_d = {24'h000000, modem_input_status};
            `UMS_OFF_MODEM_CTRL:
                rdata_d = {27'h0000000, modem_output_control_q};
            `UMS_OFF_LINE_CFG:
                rdata_d = {27'h0000000, line_config_q};
            `UMS_OFF_IRQ_STATUS:
                rdata_d = {28'h0000000, irq_status_q};
            `UMS_OFF_IRQ_MASK:
                rdata_d = {28'h0000000, irq_mask_q};
            default:
                rdata_d = 32'h00000000;
        endcase
    end

    // Captured in setup, held through the access phase
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 32'h00000000;
        end else if (setup_rd) begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rdata_q;

endmodule // ums_status_top

// >>> ums_status_props.sv
// Port-level assertions for the UART line and modem status block
`timescale 1ns/1ns
module ums_status_props (
    // Clock and reset
    input wire        clk,
    input wire        reset_n,
    // APB slave side
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    // Modem lines
    input wire        cts_n,
    input wire        dsr_n,
    input wire        ri_n,
    input wire        cd_n,
    input wire        dtr_n,
    input wire        rts_n,
    input wire        user_output_one_n,
    input wire        user_output_two_n,
    // Interrupts
    input wire        modem_irq,
    input wire        irq
);
    // ****************************************************************
    // Helper decode and state
    // ****************************************************************
    wire       acc   = psel && penable;
    wire       wr_mc = acc && pwrite && paddr == 8'h0C;
    wire       rd_ms = acc && !pwrite && paddr == 8'h08;
    wire       bad   = paddr > 8'h18 || paddr[1:0] != 2'h0;
    wire [3:0] outs  = {user_output_two_n, user_output_one_n, rts_n, dtr_n};
    wire       loop_d;
    logic      loop_q;
    logic      lp_q;
    logic [1:0] up_q;
    wire       norm  = !loop_q && !lp_q && up_q == 2'h3;

    // Loopback copy and settle count after reset
    assign loop_d = wr_mc ? pwdata[4] : loop_q;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loop_q <= 1'b0;
            lp_q   <= 1'b0;
            up_q   <= 2'h0;
        end else begin
            loop_q <= loop_d;
            lp_q   <= loop_q;
            up_q   <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    chk_pready_high: assert property (pready)
        else $error("pready low");
    chk_err_phase: assert property (pslverr |-> acc)
        else $error("pslverr outside access");
    chk_err_map: assert property (acc |-> pslverr == bad)
        else $error("pslverr wrong for address");
    chk_reset_outs: assert property (disable iff (1'b0)
        !reset_n |-> outs == 4'hF && !modem_irq && !irq)
        else $error("outputs wrong in reset");
    chk_ctl_drive: assert property (wr_mc && !pwdata[4]
        |=> outs == ~$past(pwdata[3:0]))
        else $error("modem outputs not from control");
    chk_loop_quiet: assert property (wr_mc && pwdata[4] |=> outs == 4'hF)
        else $error("modem outputs active in loopback");
    chk_edge_set: assert property (
        norm && $changed({cd_n, dsr_n, cts_n}) |=> modem_irq)
        else $error("line change missed");
    chk_ri_rise: assert property (norm && $rose(ri_n) |=> modem_irq)
        else $error("ring rise missed");
    chk_ri_fall: assert property (
        norm && !modem_irq && $fell(ri_n) && $stable({cd_n, dsr_n, cts_n})
        |=> !modem_irq)
        else $error("ring fall set change");
    chk_irq_hold: assert property (modem_irq && !rd_ms |=> modem_irq)
        else $error("modem request dropped");
    chk_read_clear: assert property (
        rd_ms && norm && $stable({cd_n, ri_n, dsr_n, cts_n}) |=> !modem_irq)
        else $error("read did not clear");
endmodule // ums_status_props

bind ums_status_top ums_status_props u_props (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
    .cd_n(cd_n), .dtr_n(dtr_n), .rts_n(rts_n),
    .user_output_one_n(user_output_one_n),
    .user_output_two_n(user_output_two_n),
    .modem_irq(modem_irq), .irq(irq)
);

// >>> ums_modem_model.sv
// Behavioural modem driving the four status input lines
`timescale 1ns/1ns
module ums_modem_model (
    // Clock
    input  wire       clk,
    // Requested levels and delay in cycles
    input  wire [3:0] want,
    input  wire [3:0] lag,
    // Lines to the block, active low
    output wire       cts_n,
    output wire       dsr_n,
    output wire       ri_n,
    output wire       cd_n
);
    logic [3:0] lines_q;
    logic [3:0] wait_q;

    // Apply requested levels once the delay has run out
    initial lines_q = 4'hF;
    initial wait_q = 4'h0;
    always @(posedge clk) begin
        if (want == lines_q)
            wait_q <= 4'h0;
        else if (wait_q >= lag)
            lines_q <= want;
        else
            wait_q <= wait_q + 4'h1;
    end
    assign {cd_n, ri_n, dsr_n, cts_n} = lines_q;
endmodule // ums_modem_model

// >>> test_uart_line_and_modem_status.sv
// Self-checking testbench for the UART line and modem status block
`timescale 1ns/1ns
module test_uart_line_and_modem_status;
    localparam logic [7:0] RXA = 8'h00, LSA = 8'h04, MSA = 8'h08;
    localparam logic [7:0] MCA = 8'h0C, CFA = 8'h10, ISA = 8'h14;
    localparam logic [7:0] MKA = 8'h18;
    logic        clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    logic        rx_v;
    logic [7:0]  rx_d;
    logic        rx_p;
    logic [3:0]  want;
    logic [3:0]  lag;
    wire         cts_n, dsr_n, ri_n, cd_n;
    wire  [3:0]  outs_n;
    wire         modem_irq;
    wire         irq;
    int          errors;
    int          check_count;
    int          cyc;
    logic [31:0] rd;
    logic        err;

    // Clock at 20 MHz
    initial clk = 1'b0;
    always #25 clk = ~clk;

    ums_status_top DUT (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_char_valid(rx_v),
        .rx_char_data(rx_d), .rx_char_parity(rx_p), .cts_n(cts_n),
        .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .dtr_n(outs_n[0]),
        .rts_n(outs_n[1]), .user_output_one_n(outs_n[2]),
        .user_output_two_n(outs_n[3]), .modem_irq(modem_irq), .irq(irq)
    );
    ums_modem_model u_modem (
        .clk(clk), .want(want), .lag(lag), .cts_n(cts_n), .dsr_n(dsr_n),
        .ri_n(ri_n), .cd_n(cd_n)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(logic [7:0] a, logic [31:0] e, string n);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    task automatic rxc(logic [7:0] d, logic p);
        @(posedge clk);
        rx_v <= 1'b1;
        rx_d <= d;
        rx_p <= p;
        @(posedge clk);
        rx_v <= 1'b0;
    endtask
    task automatic mstep(logic [3:0] lv, logic [3:0] dl);
        int i;
        @(posedge clk);
        want <= lv;
        for (i = 0; i < 40 && {cd_n, ri_n, dsr_n, cts_n} !== lv; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        chk("modem_irq", 32'(dl != 4'h0), 32'(modem_irq));
        rdc(MSA, {24'h0, ~lv, dl}, "modem_status");
        rdc(MSA, {24'h0, ~lv, 4'h0}, "modem_status_clr");
        chk("modem_irq_clr", 32'h0, 32'(modem_irq));
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        rdc(MSA, 32'h0, "modem_status_rst");
        rdc(LSA, 32'h0, "line_status_rst");
        rdc(8'h1C, 32'h0, "unmapped");
        chk("unmapped_err", 32'h1, 32'(err));
        chk("outs_rst", 32'hF, 32'(outs_n));
    endtask
    task automatic t_modem;
        logic [3:0] lvs [6] = '{4'hE, 4'hC, 4'h4, 4'h0, 4'h4, 4'hF};
        logic [3:0] dls [6] = '{4'h1, 4'h2, 4'h8, 4'h0, 4'h4, 4'hB};
        int i;
        for (i = 0; i < 6; i++) begin
            lag <= 4'(i * 2);
            mstep(lvs[i], dls[i]);
        end
    endtask
    task automatic t_loop;
        logic [3:0] ex [4] = '{4'h2, 4'h1, 4'h4, 4'h8};
        int i;
        for (i = 0; i < 4; i++) begin
            apb(1'b1, MCA, 32'h10 | (32'h1 << i));
            @(posedge clk);
            chk("outs_loop", 32'hF, 32'(outs_n));
            apb(1'b0, MSA, 32'h0);
            chk("loop_level", 32'(ex[i]), 32'(rd[7:4]));
        end
        apb(1'b1, MCA, 32'h03);
        @(posedge clk);
        chk("outs_drive", 32'hC, 32'(outs_n));
        repeat (3) apb(1'b0, MSA, 32'h0);
        chk("loop_exit", 32'h0, rd);
    endtask
    task automatic t_rx;
        int i;
        apb(1'b1, CFA, 32'h1B);
        rxc(8'h03, 1'b1);
        rdc(LSA, 32'h05, "ls_parity");
        rdc(RXA, 32'h03, "rx_single");
        rdc(LSA, 32'h00, "ls_empty");
        rxc(8'h01, 1'b1);
        rxc(8'h02, 1'b0);
        rdc(LSA, 32'h03, "ls_overrun1");
        rdc(RXA, 32'h01, "rx_kept1");
        apb(1'b1, CFA, 32'h1F);
        for (i = 0; i < 17; i++)
            rxc(8'(i), (^8'(i)) ^ (i == 0));
        rdc(LSA, 32'h07, "ls_overrun16");
        rdc(LSA, 32'h05, "ls_after_read");
        rdc(RXA, 32'h00, "rx_head");
        rdc(LSA, 32'h01, "ls_next_head");
        for (i = 1; i < 16; i++)
            rdc(RXA, 32'(i), "rx_queue");
        rdc(LSA, 32'h00, "ls_drained");
    endtask
    task automatic t_irq;
        apb(1'b1, ISA, 32'hF);
        rdc(ISA, 32'h0, "irq_status_clr");
        apb(1'b1, MKA, 32'h1);
        rxc(8'h55, 1'b0);
        @(posedge clk);
        chk("irq_on", 32'h1, 32'(irq));
        rdc(ISA, 32'h1, "irq_status");
        apb(1'b1, MKA, 32'h0);
        @(posedge clk);
        chk("irq_masked", 32'h0, 32'(irq));
        apb(1'b1, MKA, 32'h1);
        apb(1'b1, ISA, 32'h1);
        @(posedge clk);
        chk("irq_w1c", 32'h0, 32'(irq));
        rdc(RXA, 32'h55, "rx_irq_char");
    endtask

    task automatic end_of_test;
        if (errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {rx_v, rx_d, rx_p, lag} = '0;
        want = 4'hF;
        reset_n = 1'b0;
        errors = 0;
        check_count = 0;
        cyc = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        t_modem;
        t_loop;
        t_rx;
        t_irq;
        end_of_test;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_of_test;
        end
    end
endmodule // test_uart_line_and_modem_status
